// [rtl/amt_tracker.sv]
`timescale 1ns/1ns
module amt_tracker
	import amt_pkg::*;
#(
	parameter int CYCLE_CLKS = PROG_CYCLE_CLKS       // clocks per program cycle
) (
	input  wire logic              clock_in,         // 100 MHz clock
	input  wire logic              rst_in,           // async reset, active high
	input  wire logic              enable_in,        // block enable pin
	input  wire logic              minmax_select_in, // min/max select pin
	input  wire logic [DATA_W-1:0] analog_source_in, // selected analog value
	input  wire amt_src_t          source_kind_in,   // what the source is
	input  wire logic [ADDR_W-1:0] addr_in,          // register byte address
	input  wire logic [BUS_W-1:0]  wdata_in,         // register write data
	input  wire logic              wr_in,            // write strobe
	input  wire logic              rd_in,            // read strobe
	output logic      [BUS_W-1:0]  rdata_out,        // read data, cycle after strobe
	output logic      [DATA_W-1:0] analog_result_out,// clamped result for other blocks
	output logic                   cycle_tick_out    // one-cycle program cycle pulse
);

	// clamp to limits; lower applied first so upper wins on crossed limits
	// crossed limits are a setup error; favouring upper keeps the output bounded above
	function automatic logic [DATA_W-1:0] amt_clamp(input logic [DATA_W-1:0] v,
		input logic [DATA_W-1:0] lo, input logic [DATA_W-1:0] hi);
		logic [DATA_W-1:0] t;
		t = ($signed(v) < $signed(lo)) ? lo : v;
		if ($signed(t) > $signed(hi)) begin
			t = hi;
		end
		return t;
	endfunction

	// one count of headroom so that CYCLE_CLKS itself fits the width
	localparam int CNT_W = $clog2(CYCLE_CLKS + 1); // divider width

	amt_cfg_t          cfg;                      // software configuration
	logic [CNT_W-1:0]  div_cnt;                  // program cycle divider
	logic [2:0]        en_sync;                  // enable synchroniser chain
	logic [2:0]        sel_sync;                 // select synchroniser chain
	logic              en_q;                     // filtered enable
	logic              sel_q;                    // filtered select
	logic [DATA_W-1:0] min_val;                  // tracked minimum
	logic [DATA_W-1:0] max_val;                  // tracked maximum
	logic              track_valid;              // min/max seeded by a sample
	logic              rd_pend;                  // read answered next cycle
	logic [BUS_W-1:0]  rd_hold;                  // captured read word

	// divider: tick on the last count of each program cycle
	// a free-running divider keeps every evaluation on one program cycle grid
	// limitation: CYCLE_CLKS below 2 would make the tick stand on every clock
	wire               tick     = (div_cnt == CNT_W'(CYCLE_CLKS - 1));
	wire [CNT_W-1:0]   next_div = tick ? '0 : div_cnt + CNT_W'(1);

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= next_div;
		end
	end

	assign cycle_tick_out = tick;

	// pin filtering: a level counts once stages two and three agree
	// stage one may go metastable, so only stages two and three are compared
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			en_sync  <= 3'h0;
			sel_sync <= 3'h0;
		end else begin
			en_sync  <= {en_sync[1:0], enable_in};
			sel_sync <= {sel_sync[1:0], minmax_select_in};
		end
	end

	// trade-off: four clocks of latency buy immunity to single-clock glitches
	wire en_agree  = (en_sync[1] == en_sync[2]);
	wire sel_agree = (sel_sync[1] == sel_sync[2]);

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			en_q  <= 1'b0;
			sel_q <= 1'b0;
		end else begin
			if (en_agree) begin
				en_q <= en_sync[2];
			end
			if (sel_agree) begin
				sel_q <= sel_sync[2];
			end
		end
	end

	// source conditioning: physical inputs live on the 0..1000 scale
	// other kinds are already internal values and pass unchanged
	// saturating rather than wrapping keeps an overdriven input at full scale
	wire src_phys = (source_kind_in == AMT_SRC_INPUT);
	wire src_blk  = (source_kind_in == AMT_SRC_BLOCK);
	wire [DATA_W-1:0] sample =
		!src_phys ? analog_source_in :
		($signed(analog_source_in) < 0) ? ZERO_VAL :
		(analog_source_in > SCALE_MAX) ? SCALE_MAX : analog_source_in;

	// tracking: the first sample after a clear seeds both extremes
	// compares are signed so that negative flags and block results track correctly
	wire take_min = !track_valid || ($signed(sample) < $signed(min_val));
	wire take_max = !track_valid || ($signed(sample) > $signed(max_val));
	wire [DATA_W-1:0] next_min = take_min ? sample : min_val;
	wire [DATA_W-1:0] next_max = take_max ? sample : max_val;

	// output selection; select pin matters only in mode 2
	// the updated extremes are used, so a new peak shows in the same program cycle
	wire pick_max = (cfg.mode == AMT_MODE_MAX) ||
		((cfg.mode == AMT_MODE_SEL) && sel_q);
	wire pick_live = (cfg.mode == AMT_MODE_LIVE) || src_blk;
	wire [DATA_W-1:0] chosen = pick_live ? sample :
		pick_max ? next_max : next_min;
	wire [DATA_W-1:0] next_result = amt_clamp(chosen, cfg.lower, cfg.upper);
	wire disabled_clear = !en_q && cfg.rst_opt;

	// program cycle evaluation; registers change only on the tick
	// sampling only on the tick stands for one scan of the controller program
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			min_val           <= ZERO_VAL;
			max_val           <= ZERO_VAL;
			track_valid       <= 1'b0;
			analog_result_out <= ZERO_VAL;
		end else if (tick) begin
			if (en_q) begin
				min_val           <= next_min;
				max_val           <= next_max;
				track_valid       <= 1'b1;
				analog_result_out <= next_result;
			end else if (cfg.rst_opt) begin
				// zero is forced directly, the limits do not apply to it
				min_val           <= ZERO_VAL;
				max_val           <= ZERO_VAL;
				track_valid       <= 1'b0;
				analog_result_out <= ZERO_VAL;
			end
			// otherwise the output and tracking hold
		end
	end

	// register decode
	// exact match on the byte address; every other address reads as zero
	// limits come back as stored, not sign-extended
	wire hit_ctrl  = (addr_in == REG_CTRL);
	wire hit_upper = (addr_in == REG_UPPER);
	wire hit_lower = (addr_in == REG_LOWER);
	wire [BUS_W-1:0] status_word =
		{29'h0, track_valid, sel_q, en_q};
	wire [BUS_W-1:0] rd_mux =
		hit_ctrl                 ? {29'h0, cfg.rst_opt, cfg.mode} :
		hit_upper                ? {16'h0, cfg.upper} :
		hit_lower                ? {16'h0, cfg.lower} :
		(addr_in == REG_MIN)     ? {16'h0, min_val} :
		(addr_in == REG_MAX)     ? {16'h0, max_val} :
		(addr_in == REG_RESULT)  ? {16'h0, analog_result_out} :
		(addr_in == REG_STATUS)  ? status_word : 32'h0;

	// register writes; a two-bit mode field can hold only 0..3
	// writes to read-only places fall through the decode and are dropped
	// a new reset-on-disable setting acts at the next tick, not at once
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			cfg.mode    <= AMT_MODE_MIN;
			cfg.rst_opt <= 1'b0;
			cfg.upper   <= UPPER_RESET;
			cfg.lower   <= LOWER_RESET;
		end else if (wr_in) begin
			if (hit_ctrl) begin
				cfg.mode    <= amt_mode_t'(wdata_in[CTRL_MODE_LSB +: 2]);
				cfg.rst_opt <= wdata_in[CTRL_RST_BIT];
			end
			if (hit_upper) begin
				cfg.upper <= wdata_in[DATA_W-1:0];
			end
			if (hit_lower) begin
				cfg.lower <= wdata_in[DATA_W-1:0];
			end
		end
	end

	// read capture: data stands only in the cycle after the strobe
	// zero outside the answer cycle keeps a shared read bus free of stale words
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rd_pend <= 1'b0;
			rd_hold <= 32'h0;
		end else begin
			rd_pend <= rd_in;
			rd_hold <= rd_in ? rd_mux : 32'h0;
		end
	end

	assign rdata_out = rd_pend ? rd_hold : 32'h0;

	// checks on the evaluation path
	// they compare against the limits in force at the tick edge
	wire run = tick && en_q;

	a_mode_min_out: assert property (@(posedge clock_in) disable iff (rst_in)
		(run && cfg.mode == AMT_MODE_MIN && !src_blk) |=>
			analog_result_out == amt_clamp($past(next_min), $past(cfg.lower), $past(cfg.upper)))
		else $error("mode 0 output is not the clamped minimum");

	a_mode_max_out: assert property (@(posedge clock_in) disable iff (rst_in)
		(run && cfg.mode == AMT_MODE_MAX && !src_blk) |=>
			analog_result_out == amt_clamp($past(next_max), $past(cfg.lower), $past(cfg.upper)))
		else $error("mode 1 output is not the clamped maximum");

	a_sel_high_max: assert property (@(posedge clock_in) disable iff (rst_in)
		(run && cfg.mode == AMT_MODE_SEL && sel_q && !src_blk) |=>
			analog_result_out == amt_clamp($past(next_max), $past(cfg.lower), $past(cfg.upper)))
		else $error("select high did not give the maximum");

	a_sel_low_min: assert property (@(posedge clock_in) disable iff (rst_in)
		(run && cfg.mode == AMT_MODE_SEL && !sel_q && !src_blk) |=>
			analog_result_out == amt_clamp($past(next_min), $past(cfg.lower), $past(cfg.upper)))
		else $error("select low did not give the minimum");

	a_live_follow: assert property (@(posedge clock_in) disable iff (rst_in)
		(run && (cfg.mode == AMT_MODE_LIVE || src_blk)) |=>
			analog_result_out == amt_clamp($past(sample), $past(cfg.lower), $past(cfg.upper)))
		else $error("live mode output does not follow the input");

	a_disable_zero: assert property (@(posedge clock_in) disable iff (rst_in)
		(tick && disabled_clear) |=> (analog_result_out == ZERO_VAL && !track_valid && min_val == ZERO_VAL))
		else $error("reset option did not zero the block");

	a_disable_hold: assert property (@(posedge clock_in) disable iff (rst_in)
		(!en_q && !cfg.rst_opt) |=> $stable(analog_result_out))
		else $error("disabled output changed without reset option");

	a_clamp_limits: assert property (@(posedge clock_in) disable iff (rst_in)
		(run && $signed(cfg.lower) <= $signed(cfg.upper)) |=>
			($signed(analog_result_out) >= $signed($past(cfg.lower)) &&
			 $signed(analog_result_out) <= $signed($past(cfg.upper))))
		else $error("output escaped the limits");

	a_phys_scale: assert property (@(posedge clock_in) disable iff (rst_in)
		src_phys |-> ($signed(sample) >= 0 && sample <= SCALE_MAX))
		else $error("physical sample outside 0 to 1000");

	a_track_order: assert property (@(posedge clock_in) disable iff (rst_in)
		track_valid |-> ($signed(min_val) <= $signed(max_val)))
		else $error("tracked minimum above maximum");

	a_tick_spacing: assert property (@(posedge clock_in) disable iff (rst_in)
		tick |=> !tick)
		else $error("program cycle ticks back to back");

	// the result register moves only on an evaluation edge
	a_result_steady: assert property (@(posedge clock_in) disable iff (rst_in)
		!tick |=> $stable(analog_result_out))
		else $error("result changed between program cycles");

	// the extremes move only on an evaluation edge
	a_track_steady: assert property (@(posedge clock_in) disable iff (rst_in)
		!tick |=> ($stable(min_val) && $stable(max_val)))
		else $error("tracking changed between program cycles");

	// the first enabled sample after a clear is both minimum and maximum
	a_seed_both: assert property (@(posedge clock_in) disable iff (rst_in)
		(run && !track_valid) |=> (track_valid && min_val == max_val))
		else $error("first sample did not seed both extremes");

	// a choice below the lower limit leaves as the lower limit when the limits are not crossed
	a_clamp_low: assert property (@(posedge clock_in) disable iff (rst_in)
		(run && $signed(chosen) < $signed(cfg.lower) && $signed(cfg.lower) <= $signed(cfg.upper)) |=>
			(analog_result_out == $past(cfg.lower)))
		else $error("low value not raised to the lower limit");

	// a choice above the upper limit leaves as the upper limit
	a_clamp_high: assert property (@(posedge clock_in) disable iff (rst_in)
		(run && $signed(chosen) > $signed(cfg.upper)) |=> (analog_result_out == $past(cfg.upper)))
		else $error("high value not cut to the upper limit");

	// the mode field takes the written value
	a_mode_write: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && hit_ctrl) |=> (cfg.mode == $past(wdata_in[CTRL_MODE_LSB +: 2])))
		else $error("mode write did not land");

	// the upper limit takes the written value
	a_upper_write: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && hit_upper) |=> (cfg.upper == $past(wdata_in[DATA_W-1:0])))
		else $error("upper limit write did not land");

	// the lower limit takes the written value
	a_lower_write: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && hit_lower) |=> (cfg.lower == $past(wdata_in[DATA_W-1:0])))
		else $error("lower limit write did not land");

	// the clamped result can be read back as a source value
	a_result_read: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_in && addr_in == REG_RESULT) |=> (rdata_out == {16'h0, $past(analog_result_out)}))
		else $error("result read back wrong");

	// a disagreeing filter keeps the accepted enable level
	a_en_filter: assert property (@(posedge clock_in) disable iff (rst_in)
		(en_sync[1] != en_sync[2]) |=> $stable(en_q))
		else $error("enable accepted before the filter agreed");

endmodule

// [rtl/amt_pkg.sv]
// Behaviour
// - mode takes 0..3, picks min/max/live
// - mode 0 enabled: output tracked minimum
// - mode 1 enabled: output tracked maximum
// - mode 2, select low: output minimum
// - mode 2, select high: output maximum
// - select input ignored outside mode 2
// - mode 3 or block source: follow input
// - reset option, disabled: zero output, clear tracking
// - no reset option, disabled: hold output
// - enabled: output chosen by mode and select
// - below lower limit: output equals lower, or upper if the limits are crossed
// - above upper limit: output equals upper
// - source is input, output, flag or block
// - physical input values span 0 to 1000
// - clamped output readable by other blocks
package amt_pkg;
	localparam int DATA_W                = 16;       // analog value width
	localparam int ADDR_W                = 8;        // register address width
	localparam int BUS_W                 = 32;       // register data width
	// register byte addresses
	localparam logic [7:0] REG_CTRL      = 8'h00;    // mode and reset option
	localparam logic [7:0] REG_UPPER     = 8'h04;    // upper limit
	localparam logic [7:0] REG_LOWER     = 8'h08;    // lower limit
	localparam logic [7:0] REG_MIN       = 8'h0c;    // tracked minimum, read only
	localparam logic [7:0] REG_MAX       = 8'h10;    // tracked maximum, read only
	localparam logic [7:0] REG_RESULT    = 8'h14;    // clamped result, read only
	localparam logic [7:0] REG_STATUS    = 8'h18;    // filtered pin state and tracking seeded, read only
	// control field positions
	localparam int CTRL_MODE_LSB         = 0;        // mode field, two bits
	localparam int CTRL_RST_BIT          = 2;        // reset-on-disable option
	// status field positions
	localparam int STAT_EN_BIT           = 0;        // filtered enable
	localparam int STAT_SEL_BIT          = 1;        // filtered min/max select
	localparam int STAT_VALID_BIT        = 2;        // tracking seeded
	// reset values
	localparam logic [DATA_W-1:0] UPPER_RESET = 16'h7fff;  // full signed range, no clamp
	localparam logic [DATA_W-1:0] LOWER_RESET = 16'h8000;
	localparam logic [DATA_W-1:0] ZERO_VAL    = 16'h0000;
	localparam logic [DATA_W-1:0] SCALE_MAX   = 16'h03e8;  // 1000 = full input range
	// timing
	localparam int CLK_PERIOD_NS         = 10;       // 100 MHz controller clock
	localparam int PROG_CYCLE_NS         = 1000;     // program cycle time
	localparam int PROG_CYCLE_CLKS       = (PROG_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		AMT_MODE_MIN  = 2'b00,                       // output minimum
		AMT_MODE_MAX  = 2'b01,                       // output maximum
		AMT_MODE_SEL  = 2'b10,                       // select pin chooses
		AMT_MODE_LIVE = 2'b11                        // output live value
	} amt_mode_t;

	typedef enum logic [1:0] {
		AMT_SRC_INPUT  = 2'b00,                      // physical analog input
		AMT_SRC_OUTPUT = 2'b01,                      // analog output
		AMT_SRC_FLAG   = 2'b10,                      // analog flag
		AMT_SRC_BLOCK  = 2'b11                       // another block's result
	} amt_src_t;

	typedef struct packed {
		amt_mode_t           mode;                   // output selection
		logic                rst_opt;                // zero and clear when disabled
		logic [DATA_W-1:0]   upper;                  // signed upper limit
		logic [DATA_W-1:0]   lower;                  // signed lower limit
	} amt_cfg_t;
endpackage

// [dv/amt_tracker_bench.sv]
`timescale 1ns/1ns
module amt_tracker_bench;
	import amt_pkg::*;
	localparam int CYC = 8;                          // short program cycle keeps the run brief
	logic              clock_in         = 1'b0;      // bench clock
	logic              rst_in           = 1'b1;      // held high at start
	logic              enable_in        = 1'b0;      // block enable pin
	logic              minmax_select_in = 1'b0;      // min/max select pin
	logic [DATA_W-1:0] analog_source_in = '0;        // sample value
	amt_src_t          source_kind_in   = AMT_SRC_OUTPUT;
	logic [ADDR_W-1:0] addr_in          = '0;        // register address
	logic [BUS_W-1:0]  wdata_in         = '0;        // register write data
	logic              wr_in            = 1'b0;      // write strobe
	logic              rd_in            = 1'b0;      // read strobe
	logic [BUS_W-1:0]  rdata_out;                    // read data
	logic [DATA_W-1:0] analog_result_out;            // clamped result
	logic              cycle_tick_out;               // program cycle pulse
	int                n_fail           = 0;         // mismatches
	int                n_checks         = 0;         // comparisons made

	amt_tracker #(.CYCLE_CLKS(CYC)) dut (.clock_in(clock_in), .rst_in(rst_in), .enable_in(enable_in),
		.minmax_select_in(minmax_select_in), .analog_source_in(analog_source_in),
		.source_kind_in(source_kind_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .analog_result_out(analog_result_out),
		.cycle_tick_out(cycle_tick_out));

	// 100 MHz clock
	always #5 clock_in = ~clock_in;

	// verdict and end of run
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// four-state compare, reported at once
	task automatic check(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// register write, one strobe cycle
	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
		@(posedge clock_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clock_in);
		wr_in    <= 1'b0;
	endtask

	// register read; data stands one cycle only, then drops to zero
	task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] exp);
		@(posedge clock_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clock_in);
		rd_in   <= 1'b0;
		#1;
		check(rdata_out, exp);
		@(posedge clock_in);
		#1;
		check(rdata_out, '0);
	endtask

	// bounded wait for a tick, then let the evaluation edge pass
	task automatic one_cycle;
		int i;
		for (i = 0; i < 4 * CYC; i++) begin
			@(posedge clock_in);
			#1;
			if (cycle_tick_out === 1'b1) break;
		end
		if (i == 4 * CYC) begin
			n_fail++;
			test_done;
		end else begin
			@(posedge clock_in);
		end
	endtask

	// pins first, four clocks for the filters, then the sample and one evaluation
	// pins lead so that no tick mixes a new sample with a stale enable or select
	task automatic eval(input logic en, input logic sel, input amt_src_t k,
		input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] exp);
		@(posedge clock_in);
		enable_in        <= en;
		minmax_select_in <= sel;
		repeat (4) @(posedge clock_in);
		source_kind_in   <= k;
		analog_source_in <= s;
		one_cycle;
		#1;
		check({16'h0000, analog_result_out}, {16'h0000, exp});
	endtask

	// reset values, unmapped and read-only places
	task automatic t_reset;
		reg_rd(REG_UPPER, {16'h0000, UPPER_RESET});
		reg_rd(REG_LOWER, {16'h0000, LOWER_RESET});
		reg_rd(REG_CTRL, 32'h00000000);
		reg_wr(REG_MIN, 32'h00001234);
		reg_rd(REG_MIN, 32'h00000000);
		reg_rd(8'h1c, 32'h00000000);
	endtask

	// ticks stand one clock and come exactly one program cycle apart
	task automatic t_tick;
		int n;
		one_cycle;
		for (n = 1; n < 4 * CYC; n++) begin
			@(posedge clock_in);
			#1;
			if (cycle_tick_out === 1'b1) break;
		end
		check(n, CYC - 1);
		@(posedge clock_in);
		#1;
		check({31'h0, cycle_tick_out}, 32'h00000000);
	endtask

	// every mode, select only in mode 2, live sources
	task automatic t_modes;
		reg_wr(REG_CTRL, 32'h00000000);
		eval(1'b1, 1'b0, AMT_SRC_OUTPUT, 16'h0064, 16'h0064);
		eval(1'b1, 1'b0, AMT_SRC_OUTPUT, 16'hffce, 16'hffce);
		eval(1'b1, 1'b0, AMT_SRC_OUTPUT, 16'h012c, 16'hffce);
		reg_rd(REG_MIN, 32'h0000ffce);
		reg_rd(REG_MAX, 32'h0000012c);
		reg_rd(REG_STATUS, 32'h00000005);
		eval(1'b1, 1'b1, AMT_SRC_FLAG, 16'h00c8, 16'hffce);
		reg_rd(REG_STATUS, 32'h00000007);
		reg_wr(REG_CTRL, 32'h00000001);
		eval(1'b1, 1'b0, AMT_SRC_OUTPUT, 16'h00c8, 16'h012c);
		reg_wr(REG_CTRL, 32'h00000002);
		eval(1'b1, 1'b1, AMT_SRC_OUTPUT, 16'h0000, 16'h012c);
		eval(1'b1, 1'b0, AMT_SRC_OUTPUT, 16'h0000, 16'hffce);
		reg_wr(REG_CTRL, 32'h00000003);
		eval(1'b1, 1'b1, AMT_SRC_OUTPUT, 16'h004d, 16'h004d);
		reg_wr(REG_CTRL, 32'h00000000);
		eval(1'b1, 1'b0, AMT_SRC_BLOCK, 16'h0037, 16'h0037);
		reg_wr(REG_CTRL, 32'h00000003);
		eval(1'b1, 1'b0, AMT_SRC_INPUT, 16'h07d0, SCALE_MAX);
		eval(1'b1, 1'b0, AMT_SRC_INPUT, 16'hfffb, ZERO_VAL);
	endtask

	// limits clamp both ways; result readable as a source
	task automatic t_clamp;
		reg_wr(REG_UPPER, 32'h000000fa);
		reg_wr(REG_LOWER, 32'h0000ffec);
		reg_wr(REG_CTRL, 32'h00000001);
		eval(1'b1, 1'b0, AMT_SRC_OUTPUT, 16'h0000, 16'h00fa);
		reg_rd(REG_RESULT, 32'h000000fa);
		reg_wr(REG_CTRL, 32'h00000000);
		eval(1'b1, 1'b0, AMT_SRC_OUTPUT, 16'h0000, 16'hffec);
	endtask

	// disable with and without the reset option; a mode change does not reach a held output
	task automatic t_disable;
		eval(1'b0, 1'b0, AMT_SRC_OUTPUT, 16'h03e7, 16'hffec);
		reg_wr(REG_CTRL, 32'h00000003);
		eval(1'b0, 1'b1, AMT_SRC_OUTPUT, 16'h03e7, 16'hffec);
		reg_wr(REG_CTRL, 32'h00000007);
		reg_rd(REG_CTRL, 32'h00000007);
		eval(1'b0, 1'b0, AMT_SRC_OUTPUT, 16'h03e7, ZERO_VAL);
		reg_rd(REG_MAX, 32'h00000000);
		reg_wr(REG_UPPER, {16'h0000, UPPER_RESET});
		reg_wr(REG_LOWER, {16'h0000, LOWER_RESET});
		reg_wr(REG_CTRL, 32'h00000001);
		eval(1'b1, 1'b0, AMT_SRC_OUTPUT, 16'h000a, 16'h000a);
	endtask

	// a reset in mid-run clears the result and the configuration at once
	task automatic t_midreset;
		reg_wr(REG_UPPER, 32'h00000055);
		@(posedge clock_in);
		rst_in           <= 1'b1;
		analog_source_in <= 16'h0021;
		repeat (2) @(posedge clock_in);
		rst_in           <= 1'b0;
		#1;
		check({16'h0000, analog_result_out}, 32'h00000000);
		reg_rd(REG_UPPER, {16'h0000, UPPER_RESET});
		reg_rd(REG_CTRL, 32'h00000000);
		eval(1'b1, 1'b0, AMT_SRC_OUTPUT, 16'h0021, 16'h0021);
	endtask

	// main sequence: two-cycle reset, then the scenarios
	initial begin
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		t_reset;
		t_tick;
		t_modes;
		t_clamp;
		t_disable;
		t_midreset;
		test_done;
	end
endmodule
